//--- include/rtc_serial_map.svh
// constant map of the hidden clock: register indices, field bits, reset values and timing
`ifndef RTC_SERIAL_MAP_SVH
`define RTC_SERIAL_MAP_SVH
`define RTC_UNLOCK_PATTERN   64'h5ca33ac55ca33ac5
`define RTC_BIT_COUNT        7'h40
`define RTC_REG_HUNDREDTHS   3'h0
`define RTC_REG_SECONDS      3'h1
`define RTC_REG_MINUTES      3'h2
`define RTC_REG_HOURS        3'h3
`define RTC_REG_WEEKDAY      3'h4
`define RTC_REG_DATE         3'h5
`define RTC_REG_MONTH        3'h6
`define RTC_REG_YEAR         3'h7
`define RTC_USED_BITS        64'hff1f3f37bf7f7fff
`define RTC_HOUR_MODE_BIT    7
`define RTC_HOUR_PM_BIT      5
`define RTC_DAY_ABORT_BIT    4
`define RTC_DAY_OSC_BIT      5
`define RTC_WEEKDAY_RESET    8'h31
`define RTC_HOUR_RESET       8'h00
`define RTC_OTHER_RESET      8'h00
`define RTC_TICK_NS          10000000
`define RTC_CLK_PERIOD_NS    10
`define RTC_TICK_CYCLES      (`RTC_TICK_NS / `RTC_CLK_PERIOD_NS)
`define RTC_FIFO_DEPTH       16
`endif

//--- include/rtc_serial_pkg.sv
// shared types of the hidden clock
package rtc_serial_pkg;
	// access phase of the serial clock port
	typedef enum logic [1:0] {
		ST_MATCH,
		ST_DEAD,
		ST_XFER,
		ST_COMMIT
	} phase_type;
	// one written clock register waiting to be committed
	typedef struct packed {
		logic [2:0] idx;
		logic [7:0] value;
	} commit_word_type;
endpackage : rtc_serial_pkg

//--- rtl/rtc_byte_fifo.sv
// parameterised synchronous fifo with valid and ready on both sides
`timescale 1ns/10ps
module rtc_byte_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 16
) (
	input  wire logic             sys_clk_in,
	input  wire logic             sys_rst_in,
	input  wire logic             flush_in,
	input  wire logic             push_valid_in,
	output logic                  push_ready_out,
	input  wire logic [WIDTH-1:0] push_data_in,
	output logic                  pop_valid_out,
	input  wire logic             pop_ready_in,
	output logic      [WIDTH-1:0] pop_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];          // storage words
	logic [AW-1:0]    wr_ptr, next_wr_ptr;  // write position
	logic [AW-1:0]    rd_ptr, next_rd_ptr;  // read position
	logic [AW:0]      count, next_count;    // words held
	logic             do_push, do_pop;      // accepted transfers

	assign push_ready_out = (count != (AW+1)'(DEPTH));
	assign pop_valid_out  = (count != '0);
	assign pop_data_out   = mem[rd_ptr];
	assign do_push        = push_valid_in & push_ready_out;
	assign do_pop         = pop_valid_out & pop_ready_in;

	// pointer and count update, flush empties the buffer
	always_comb begin
		next_wr_ptr = wr_ptr + AW'(do_push);
		next_rd_ptr = rd_ptr + AW'(do_pop);
		next_count  = count + (AW+1)'(do_push) - (AW+1)'(do_pop);
		if (flush_in) begin
			next_wr_ptr = '0;
			next_rd_ptr = '0;
			next_count  = '0;
		end
	end

	// register pointers and write storage
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
		if (do_push && !flush_in) begin
			mem[wr_ptr] <= push_data_in;
		end
	end
endmodule : rtc_byte_fifo

//--- rtl/hidden_rtc_serial_access.sv
// hidden real-time clock reached by a serial unlock and transfer over data line 0
// Overview of operation
// - unlock pattern is C5 3A A3 5C twice
// - each pattern byte sent lsb first
// - hours bit 7 high selects 12-hour
// - 12-hour mode: hours bit 5 is afternoon
// - 24-hour mode: bit 5 is tens for 20-23
// - weekday bit 4 high ignores abort pin
// - abort low ends transfer, registers unchanged
// - weekday bit 5 high stops the oscillator
// - abort-ignore and oscillator-off bits reset high
// - unused bits of registers 1-6 read zero
// - writes to unused bits are discarded
// - mismatch freezes pointer, later writes ignored
// - read cycle restarts recognition at bit 0
// - after match 64 cycles move clock data
// - transfer walks bit 0 reg 0 to bit 7 reg 7
`timescale 1ns/10ps
`include "rtc_serial_map.svh"
module hidden_rtc_serial_access #(
	parameter int TICK_CYCLES = `RTC_TICK_CYCLES
) (
	input  wire logic sys_clk_in,
	input  wire logic sys_rst_in,
	input  wire logic chip_enable_n_in,        // strobe: chip enable
	input  wire logic write_enable_n_in,       // strobe: write enable
	input  wire logic output_enable_n_in,      // strobe: output enable
	input  wire logic abort_n_in,              // abort pin, low aborts
	input  wire logic serial_data_line_in,     // data line 0 level
	output logic      serial_data_line_out,    // data line 0 driven value
	output logic      serial_data_line_oe_n_out, // low while driving line
	output logic      memory_block_out,        // memory access inhibited
	output logic      osc_running_out          // timebase running
);
	// stream constants held as vectors so that the pointer can pick single bits from them
	localparam logic [63:0] UNLOCK_PATTERN = `RTC_UNLOCK_PATTERN; // expected unlock stream, bit 0 first
	localparam logic [63:0] USED_BITS      = `RTC_USED_BITS;      // implemented clock register bits
	rtc_serial_pkg::phase_type       phase, next_phase;   // access phase
	logic [6:0]                      ptr, next_ptr;       // bit pointer
	logic [63:0]                     regs, next_regs;     // eight clock registers
	logic [63:0]                     snap, next_snap;     // read image for transfer
	logic [7:0]                      shift, next_shift;   // incoming written byte
	logic                            wr_act_q, rd_act_q;  // strobe phases last cycle
	logic                            data_q;              // line level last cycle
	logic                            dout, next_dout;     // registered output bit
	logic [31:0]                     tick, next_tick;     // timebase divider
	logic                            wr_act, rd_act;      // strobe phases now
	logic                            wr_end, rd_end;      // cycle completion pulses
	logic                            abort_now;           // gated abort
	logic                            push_valid, push_ready;
	logic                            pop_valid, pop_ready, flush;
	rtc_serial_pkg::commit_word_type push_word, pop_word;

	assign wr_act    = !chip_enable_n_in && !write_enable_n_in;
	assign rd_act    = !chip_enable_n_in && !output_enable_n_in && write_enable_n_in;
	assign wr_end    = wr_act_q && !wr_act;
	assign rd_end    = rd_act_q && !rd_act;
	assign abort_now = !abort_n_in && !regs[32+`RTC_DAY_ABORT_BIT];

	// strobe history, line sample and output bit registers
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			wr_act_q <= 1'b0;
			rd_act_q <= 1'b0;
			data_q   <= 1'b0;
			dout     <= 1'b0;
		end else begin
			wr_act_q <= wr_act;
			rd_act_q <= rd_act;
			data_q   <= serial_data_line_in;
			dout     <= next_dout;
		end
	end

	// line is driven only during a read cycle of a transfer
	assign serial_data_line_out      = dout;
	assign serial_data_line_oe_n_out = !(phase == rtc_serial_pkg::ST_XFER && rd_act);
	assign memory_block_out          = (phase == rtc_serial_pkg::ST_XFER);
	assign osc_running_out           = !regs[32+`RTC_DAY_OSC_BIT];

	// written byte is queued with its register index
	assign push_word.idx   = ptr[5:3];
	assign push_word.value = {data_q, shift[7:1]};
	assign push_valid      = phase == rtc_serial_pkg::ST_XFER && wr_end && ptr[2:0] == 3'h7 && !abort_now;
	assign pop_ready       = (phase == rtc_serial_pkg::ST_COMMIT);
	assign flush           = abort_now;

	rtc_byte_fifo #(
		.WIDTH ($bits(rtc_serial_pkg::commit_word_type)),
		.DEPTH (`RTC_FIFO_DEPTH)
	) commit_fifo (
		.sys_clk_in     (sys_clk_in),
		.sys_rst_in     (sys_rst_in),
		.flush_in       (flush),
		.push_valid_in  (push_valid),
		.push_ready_out (push_ready),
		.push_data_in   (push_word),
		.pop_valid_out  (pop_valid),
		.pop_ready_in   (pop_ready),
		.pop_data_out   (pop_word)
	);

	// recognition and transfer sequencing
	always_comb begin
		next_phase = phase;
		next_ptr   = ptr;
		next_shift = shift;
		next_snap  = snap;
		next_dout  = snap[ptr[5:0]];
		case (phase)
			rtc_serial_pkg::ST_MATCH, rtc_serial_pkg::ST_DEAD: begin
				if (rd_end) begin
					next_phase = rtc_serial_pkg::ST_MATCH;
					next_ptr   = 7'h00;
				end else if (wr_end && phase == rtc_serial_pkg::ST_MATCH) begin
					if (data_q == UNLOCK_PATTERN[ptr[5:0]]) begin
						next_ptr = ptr + 7'h01;
						if (ptr == `RTC_BIT_COUNT - 7'h01) begin
							next_phase = rtc_serial_pkg::ST_XFER;
							next_ptr   = 7'h00;
							next_snap  = regs & `RTC_USED_BITS;
						end
					end else begin
						next_phase = rtc_serial_pkg::ST_DEAD;
					end
				end
			end
			rtc_serial_pkg::ST_XFER: begin
				if (abort_now) begin
					next_phase = rtc_serial_pkg::ST_MATCH;
					next_ptr   = 7'h00;
				end else if ((wr_end && push_ready) || rd_end) begin
					if (wr_end) begin
						next_shift = {data_q, shift[7:1]};
					end
					next_ptr = ptr + 7'h01;
					if (ptr == `RTC_BIT_COUNT - 7'h01) begin
						next_phase = rtc_serial_pkg::ST_COMMIT;
						next_ptr   = 7'h00;
					end
				end
			end
			rtc_serial_pkg::ST_COMMIT: begin
				if (!pop_valid) begin
					next_phase = rtc_serial_pkg::ST_MATCH;
				end
			end
			default: begin
				next_phase = rtc_serial_pkg::ST_MATCH;
				next_ptr   = 7'h00;
			end
		endcase
	end

	// sequencer registers
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			phase <= rtc_serial_pkg::ST_MATCH;
			ptr   <= 7'h00;
			shift <= 8'h00;
			snap  <= 64'h0;
		end else begin
			phase <= next_phase;
			ptr   <= next_ptr;
			shift <= next_shift;
			snap  <= next_snap;
		end
	end

	// two-digit bcd increment with wrap
	function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] maxv, input logic [7:0] minv);
		if (v == maxv) begin
			return minv;
		end else if (v[3:0] == 4'h9) begin
			return {v[7:4] + 4'h1, 4'h0};
		end else begin
			return v + 8'h01;
		end
	endfunction : bcd_inc

	// timebase and register file; a committed byte beats the tick
	always_comb begin
		logic [7:0] hr;
		logic       day_carry;
		hr         = regs[31:24];
		day_carry  = 1'b0;
		next_regs  = regs;
		next_tick  = tick;
		if (!regs[32+`RTC_DAY_OSC_BIT]) begin
			next_tick = (tick == 32'(TICK_CYCLES - 1)) ? 32'h0 : tick + 32'h1;
			if (tick == 32'(TICK_CYCLES - 1)) begin
				next_regs[7:0] = bcd_inc(regs[7:0], 8'h99, 8'h00);
				if (regs[7:0] == 8'h99) begin
					next_regs[15:8] = bcd_inc(regs[15:8] & 8'h7f, 8'h59, 8'h00);
					if ((regs[15:8] & 8'h7f) == 8'h59) begin
						next_regs[23:16] = bcd_inc(regs[23:16] & 8'h7f, 8'h59, 8'h00);
						if ((regs[23:16] & 8'h7f) == 8'h59) begin
							if (hr[`RTC_HOUR_MODE_BIT]) begin
								if ((hr & 8'h1f) == 8'h11) begin
									hr        = {hr[7:6], !hr[5], 5'h12};
									day_carry = hr[5] == 1'b0;
								end else begin
									hr = {hr[7:5], 5'(bcd_inc(hr & 8'h1f, 8'h12, 8'h01))};
								end
							end else begin
								day_carry = (hr & 8'h3f) == 8'h23;
								hr = {2'b00, 6'(bcd_inc(hr & 8'h3f, 8'h23, 8'h00))};
							end
							next_regs[31:24] = hr;
							if (day_carry) begin
								next_regs[34:32] = (regs[34:32] == 3'h7) ? 3'h1 : regs[34:32] + 3'h1;
							end
						end
					end
				end
			end
		end
		if (pop_valid && pop_ready) begin
			next_regs[{pop_word.idx, 3'h0} +: 8] = pop_word.value & USED_BITS[{pop_word.idx, 3'h0} +: 8];
		end
	end

	// register file storage
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			regs  <= {24'h0, `RTC_WEEKDAY_RESET, `RTC_HOUR_RESET, 24'h0};
			tick  <= 32'h0;
		end else begin
			regs  <= next_regs;
			tick  <= next_tick;
		end
	end

	// checks below run on the system clock and rest while reset is high
	// they watch the sequencer, the register file and the line drive enable
	// a tick and a commit in one cycle are excluded where the commit would win
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);

	sequence full_match_s;
		phase == rtc_serial_pkg::ST_MATCH && wr_end && ptr == 7'h3f
		&& data_q == UNLOCK_PATTERN[63];
	endsequence
	sequence mismatch_s;
		phase == rtc_serial_pkg::ST_MATCH && wr_end && !rd_end
		&& data_q != UNLOCK_PATTERN[ptr[5:0]];
	endsequence

	// recognition checks
	unlock_enters_xfer_a: assert property (full_match_s |=> phase == rtc_serial_pkg::ST_XFER && ptr == 7'h00)
		else $error("full pattern match did not open transfer");
	match_advances_a: assert property (phase == rtc_serial_pkg::ST_MATCH && wr_end && !rd_end && ptr < 7'h3f
		&& data_q == UNLOCK_PATTERN[ptr[5:0]] |=> ptr == $past(ptr) + 7'h01)
		else $error("matching bit did not advance pointer");
	mismatch_freeze_a: assert property (mismatch_s |=> phase == rtc_serial_pkg::ST_DEAD
		##0 (ptr == $past(ptr)))
		else $error("mismatch did not freeze recognition");
	read_restart_a: assert property (phase != rtc_serial_pkg::ST_XFER && phase != rtc_serial_pkg::ST_COMMIT
		&& rd_end |=> phase == rtc_serial_pkg::ST_MATCH && ptr == 7'h00)
		else $error("read cycle did not restart recognition");
	// abort and oscillator checks
	abort_keeps_regs_a: assert property (phase == rtc_serial_pkg::ST_XFER && abort_now
		|=> phase == rtc_serial_pkg::ST_MATCH ##1 !pop_valid)
		else $error("abort did not end transfer cleanly");
	abort_ignored_a: assert property (phase == rtc_serial_pkg::ST_XFER && !abort_n_in
		&& regs[32+`RTC_DAY_ABORT_BIT] && !wr_end && !rd_end |=> phase == rtc_serial_pkg::ST_XFER)
		else $error("abort pin acted while masked");
	osc_stop_a: assert property (regs[32+`RTC_DAY_OSC_BIT] && !pop_valid |=> $stable(regs[7:0]))
		else $error("time advanced with oscillator off");
	// transfer checks: an unused bit position is driven out as zero
	zero_bits_a: assert property (phase == rtc_serial_pkg::ST_XFER && rd_act_q && !USED_BITS[ptr[5:0]]
		|-> !serial_data_line_out)
		else $error("unused clock bit read as one");
	xfer_blocks_mem_a: assert property (phase == rtc_serial_pkg::ST_XFER |-> memory_block_out)
		else $error("memory not blocked during transfer");
	xfer_end_a: assert property (phase == rtc_serial_pkg::ST_XFER && ptr == 7'h3f && rd_end && !abort_now
		|=> phase == rtc_serial_pkg::ST_COMMIT ##[1:9] phase == rtc_serial_pkg::ST_MATCH)
		else $error("transfer did not return to memory access");
	// a written transfer cycle steps the pointer by one
	xfer_write_step_a: assert property (phase == rtc_serial_pkg::ST_XFER && wr_end && !abort_now && ptr < 7'h3f
		|=> phase == rtc_serial_pkg::ST_XFER && ptr == $past(ptr) + 7'h01)
		else $error("write cycle did not step the transfer pointer");
	// the line is driven in transfer reads and released outside a transfer
	read_drives_line_a: assert property (phase == rtc_serial_pkg::ST_XFER && rd_act |-> !serial_data_line_oe_n_out)
		else $error("transfer read did not drive the line");
	idle_line_free_a: assert property (phase != rtc_serial_pkg::ST_XFER |-> serial_data_line_oe_n_out)
		else $error("line driven outside a transfer");

	// one tick that carries out of the minutes into the hour, with no commit in that cycle
	sequence hour_carry_s;
		!regs[32+`RTC_DAY_OSC_BIT] && tick == 32'(TICK_CYCLES - 1) && !(pop_valid && pop_ready)
		&& regs[7:0] == 8'h99 && regs[14:8] == 7'h59 && regs[22:16] == 7'h59;
	endsequence

	// hour register at a carry, in both formats
	pm_toggle_a: assert property (hour_carry_s ##0 regs[31] && regs[28:24] == 5'h11
		|=> regs[31:24] == {$past(regs[31:30]), !$past(regs[29]), 5'h12})
		else $error("twelve-hour carry did not flip the afternoon flag");
	tens_hour_a: assert property (hour_carry_s ##0 !regs[31] && regs[27:24] == 4'h9
		|=> regs[31:24] == {2'b00, 2'($past(regs[29:28]) + 2'h1), 4'h0})
		else $error("twenty-four-hour carry did not step the tens digit");

	// recognition stays dead until a read cycle
	dead_ignores_a: assert property (phase == rtc_serial_pkg::ST_DEAD && !rd_end
		|=> phase == rtc_serial_pkg::ST_DEAD && ptr == $past(ptr))
		else $error("write advanced a dead recognition");
	// no unused bit is ever held in the register file
	unused_zero_a: assert property ((regs & ~USED_BITS) == 64'h0)
		else $error("unused register bit held a one");
endmodule : hidden_rtc_serial_access

//--- sim/rtc_host_model.sv
// host memory controller model: strobes, abort pin and the shared data line 0
`timescale 1ns/10ps
module rtc_host_model (
	input  wire logic sys_clk_in,
	input  wire logic dev_data_in,
	input  wire logic dev_oe_n_in,
	output logic      chip_enable_n_out,
	output logic      write_enable_n_out,
	output logic      output_enable_n_out,
	output logic      abort_n_out,
	output logic      line_out
);
	// unlock pattern, byte c5 first in the low bits
	localparam logic [63:0] UNLOCK = {8'h5c, 8'ha3, 8'h3a, 8'hc5, 8'h5c, 8'ha3, 8'h3a, 8'hc5};
	logic drv;    // last bit the host put on the line
	logic drv_en; // host is driving the line
	logic dummy;  // read data thrown away
	// released line shows the inverse of the last host bit, never a stale copy
	assign line_out = !dev_oe_n_in ? dev_data_in : (drv_en ? drv : ~drv);
	// idle strobes at time zero
	initial begin
		{chip_enable_n_out, write_enable_n_out, output_enable_n_out, abort_n_out} = 4'hf;
		{drv, drv_en} = 2'h0;
	end
	// one write cycle: one active edge, then one idle edge
	task wr_bit(input logic b);
		@(posedge sys_clk_in);
		#1;
		{chip_enable_n_out, write_enable_n_out, drv, drv_en} = {2'h0, b, 1'b1};
		@(posedge sys_clk_in);
		#1;
		{chip_enable_n_out, write_enable_n_out, drv_en} = 3'h6;
	endtask : wr_bit
	// one read cycle: data taken at the second active edge, then released
	task rd_bit(output logic b);
		@(posedge sys_clk_in);
		#1;
		{chip_enable_n_out, output_enable_n_out} = 2'h0;
		repeat (2) @(posedge sys_clk_in);
		b = line_out;
		#1;
		{chip_enable_n_out, output_enable_n_out} = 2'h3;
	endtask : rd_bit
	// read restarts recognition, then the pattern goes out lsb first
	task unlock;
		rd_bit(dummy);
		for (int i = 0; i < 64; i++) wr_bit(UNLOCK[i]);
	endtask : unlock
	// transfers walk bit 0 of register 0 up to bit 7 of register 7
	task xfer_rd(output logic [63:0] v);
		for (int i = 0; i < 64; i++) rd_bit(v[i]);
	endtask : xfer_rd
	task xfer_wr(input logic [63:0] v);
		for (int i = 0; i < 64; i++) wr_bit(v[i]);
	endtask : xfer_wr
	// abort pin low for one cycle
	task pulse_abort;
		@(posedge sys_clk_in);
		#1;
		abort_n_out = 1'b0;
		@(posedge sys_clk_in);
		#1;
		abort_n_out = 1'b1;
	endtask : pulse_abort
endmodule : rtc_host_model

//--- sim/hidden_rtc_serial_access_tb.sv
// self-checking bench of the hidden clock serial access
`timescale 1ns/10ps
module hidden_rtc_serial_access_tb;
	logic        sys_clk_in;   // 100 mhz clock
	logic        sys_rst_in;   // synchronous reset
	logic        ce_n;         // chip enable from host
	logic        we_n;         // write enable from host
	logic        oe_n;         // output enable from host
	logic        abort_n;      // abort pin
	logic        line;         // wire level of data line 0
	logic        dev_data;     // device data bit
	logic        dev_oe_n;     // device drive enable, low drives
	logic        mem_block;    // memory access inhibited
	logic        osc_run;      // timebase running
	logic [63:0] rd_val;       // last transfer read back
	logic        dummy;        // discarded read bit
	int          err_count;    // mismatches
	int          check_count;  // comparisons
	// clock generator
	always #5 sys_clk_in = ~sys_clk_in;
	// design with a short tick so the timebase moves in simulation
	hidden_rtc_serial_access #(.TICK_CYCLES(4)) i_dut (
		.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .chip_enable_n_in(ce_n),
		.write_enable_n_in(we_n), .output_enable_n_in(oe_n), .abort_n_in(abort_n),
		.serial_data_line_in(line), .serial_data_line_out(dev_data),
		.serial_data_line_oe_n_out(dev_oe_n), .memory_block_out(mem_block), .osc_running_out(osc_run));
	// host on the far side
	rtc_host_model i_host (
		.sys_clk_in(sys_clk_in), .dev_data_in(dev_data), .dev_oe_n_in(dev_oe_n),
		.chip_enable_n_out(ce_n), .write_enable_n_out(we_n), .output_enable_n_out(oe_n),
		.abort_n_out(abort_n), .line_out(line));
	// compare and count
	task check(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	// let pending state updates or a commit land
	task settle(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask : settle
	// stop the timebase first, so a later write cannot race a tick while it commits
	task osc_stop;
		i_host.unlock();
		i_host.xfer_wr(64'h0000002000000000);
		settle(10);
		check(64'(osc_run), 64'h0);
	endtask : osc_stop
	// reset values, read transfer and return to memory access
	task s_reset;
		check(64'(osc_run), 64'h0);
		i_host.unlock();
		settle(2);
		check(64'(mem_block), 64'h1);
		i_host.xfer_rd(rd_val);
		settle(2);
		check(64'(mem_block), 64'h0);
		check(rd_val, 64'h0000003100000000);
	endtask : s_reset
	// hours rollover in 24-hour and 12-hour modes
	task s_count(input logic [7:0] hr, input logic [7:0] exp_hr);
		osc_stop();
		i_host.unlock();
		i_host.xfer_wr({8'h00, 8'h01, 8'h01, 8'h01, hr, 8'h59, 8'h59, 8'h99});
		settle(10);
		check(64'(osc_run), 64'h1);
		i_host.unlock();
		i_host.xfer_rd(rd_val);
		check(64'(rd_val[31:24]), 64'(exp_hr));
	endtask : s_count
	// abort with the abort bit clear ends the transfer and keeps registers
	task s_abort;
		i_host.unlock();
		for (int i = 0; i < 40; i++) i_host.wr_bit(1'b0);
		i_host.pulse_abort();
		settle(2);
		check(64'(mem_block), 64'h0);
		i_host.unlock();
		i_host.xfer_rd(rd_val);
		check(64'(rd_val[39:24]), 64'h01b2);
	endtask : s_abort
	// all ones written: unused bits read zero, abort then ignored, oscillator off
	task s_mask;
		osc_stop();
		i_host.unlock();
		i_host.xfer_wr(64'hffffffffffffffff);
		settle(10);
		check(64'(osc_run), 64'h0);
		i_host.unlock();
		i_host.pulse_abort();
		settle(2);
		check(64'(mem_block), 64'h1);
		i_host.xfer_rd(rd_val);
		check(rd_val, 64'hff1f3f37bf7f7fff);
	endtask : s_mask
	// wrong bit freezes recognition; a read restarts it
	task s_mismatch;
		i_host.rd_bit(dummy);
		for (int i = 0; i < 64; i++) i_host.wr_bit(i_host.UNLOCK[i] ^ (i == 10));
		settle(2);
		check(64'(mem_block), 64'h0);
		for (int i = 0; i < 64; i++) i_host.wr_bit(i_host.UNLOCK[i]);
		settle(2);
		check(64'(mem_block), 64'h0);
		i_host.unlock();
		settle(2);
		check(64'(mem_block), 64'h1);
		i_host.xfer_rd(rd_val);
		check(rd_val, 64'hff1f3f37bf7f7fff);
	endtask : s_mismatch
	// verdict and end of run
	task stop_test;
		if (err_count == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	// main sequence
	initial begin
		{sys_clk_in, sys_rst_in, err_count, check_count} = {2'h1, 64'h0};
		repeat (8) @(posedge sys_clk_in);
		#1;
		sys_rst_in = 1'b0;
		s_reset();
		s_count(8'h19, 8'h20);
		s_count(8'h91, 8'hb2);
		s_abort();
		s_mask();
		s_mismatch();
		stop_test();
	end
	// watchdog: the whole run needs well under 8000 cycles
	initial begin
		#300000;
		err_count++;
		stop_test();
	end
endmodule : hidden_rtc_serial_access_tb
